/* File: verilog/serial_control_port_manager.sv */
module serial_control_port_manager #(
  parameter int HOST_DIV       = scp_pkg::DIV_HOST,
  parameter int PANEL_DIV_FAST = scp_pkg::DIV_PANEL_FAST,
  parameter int PANEL_DIV_SLOW = scp_pkg::DIV_PANEL_SLOW
) (
  // Clock and reset
  input  wire logic                          sys_clk,
  input  wire logic                          srst,
  // Avalon-MM slave
  input  wire logic [5:0]                    avs_address,
  input  wire logic                          avs_read,
  input  wire logic                          avs_write,
  input  wire logic [31:0]                   avs_writedata,
  output logic      [31:0]                   avs_readdata,
  output logic                               avs_waitrequest,
  // Interrupt
  output logic                               irq,
  // Serial control ports
  input  wire logic [scp_pkg::NUM_PORTS-1:0] port_rxd,
  output logic      [scp_pkg::NUM_PORTS-1:0] port_txd,
  output logic      [scp_pkg::NUM_PORTS-1:0] terminal_mode,
  // Panel network
  input  wire logic                          panel_rxd,
  output logic                               panel_txd,
  output logic                               panel_de,
  // Non-volatile configuration store
  output logic                               nv_wr_stb,
  output logic      [31:0]                   nv_wr_data
);
  localparam int NP  = scp_pkg::NUM_PORTS;
  localparam int NCH = scp_pkg::NUM_CH;
  localparam int DW  = scp_pkg::DIV_W;

  if (HOST_DIV < scp_pkg::DIV_MIN || PANEL_DIV_FAST < scp_pkg::DIV_MIN ||
      PANEL_DIV_SLOW < scp_pkg::DIV_MIN || PANEL_DIV_SLOW >= (1 << DW) ||
      PANEL_DIV_FAST >= (1 << DW) || HOST_DIV >= (1 << DW)) begin : g_chk
    $error("Baud divisor out of range");
  end

  // Pin synchronisers, panel in the top bit
  logic [NCH-1:0] rxd_meta_r;
  logic [NCH-1:0] rxd_sync_r;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      rxd_meta_r <= '1;
      rxd_sync_r <= '1;
    end else begin
      rxd_meta_r <= {panel_rxd, port_rxd};
      rxd_sync_r <= rxd_meta_r;
    end
  end

  // Registers
  logic [NP-1:0]                mode_r;
  logic [NP-1:0]                mode_nxt;
  logic                         slow_r;
  logic [scp_pkg::STATUS_W-1:0] status_r;
  logic [scp_pkg::STATUS_W-1:0] status_nxt;
  logic [scp_pkg::STATUS_W-1:0] mask_r;
  logic [31:0]                  cfg_r;
  logic                         ack_r;
  logic [31:0]                  rdata_r;

  // Channel wires
  logic [NCH-1:0] rx_in;
  logic [NCH-1:0] rx_stb;
  logic [NCH-1:0] rx_ferr;
  logic [NCH-1:0] tx_go;
  logic [NCH-1:0] tx_busy;
  logic [NCH-1:0] txd_w;
  logic [NCH-1:0] sel_data;
  logic [NCH-1:0] rx_full_r;
  logic [NCH-1:0] rx_ovr;
  logic [7:0]     rx_byte   [NCH];
  logic [7:0]     rx_data_r [NCH];
  logic [DW-1:0]  ch_div    [NCH];
  logic [NP-1:0]  cmd_done;
  logic [NP-1:0]  cmd_mach;

  // Bus decode
  wire req      = avs_read | avs_write;
  wire sel_ctrl = avs_address == scp_pkg::ADDR_CTRL;
  wire sel_stat = avs_address == scp_pkg::ADDR_STATUS;
  wire sel_mask = avs_address == scp_pkg::ADDR_MASK;
  wire sel_link = avs_address == scp_pkg::ADDR_LINK;
  wire sel_cfg  = avs_address == scp_pkg::ADDR_CFG;
  // A write to a busy transmitter waits here instead of being dropped
  wire tx_block = avs_write & |(sel_data & tx_busy);
  wire take     = req & ~ack_r & ~tx_block;
  wire wr_do    = avs_write & ack_r;
  wire rd_do    = avs_read & ack_r;
  wire wr_ctrl  = wr_do & sel_ctrl;

  assign avs_waitrequest = req & ~ack_r;
  assign avs_readdata    = rdata_r;

  for (genvar g = 0; g < NCH; g++) begin : g_ch
    assign sel_data[g] = avs_address == 6'(int'(scp_pkg::ADDR_DATA0) + scp_pkg::DATA_STEP * g);
    assign tx_go[g]    = wr_do & sel_data[g];
    assign rx_ovr[g]   = rx_stb[g] & rx_full_r[g] & ~(rd_do & sel_data[g]);
    if (g < NP) begin : g_host
      assign ch_div[g] = DW'(HOST_DIV); // R02
      assign rx_in[g]  = rxd_sync_r[g];
    end else begin : g_panel
      assign ch_div[g] = slow_r ? DW'(PANEL_DIV_SLOW) : DW'(PANEL_DIV_FAST); // R09
      // Half duplex: own echo on the shared pair is not received
      assign rx_in[g]  = rxd_sync_r[g] | tx_busy[g]; // R12
    end

    uart_rx u_rx (
      .sys_clk   (sys_clk),
      .srst      (srst),
      .rxd       (rx_in[g]),
      .div       (ch_div[g]),
      .data      (rx_byte[g]),
      .valid     (rx_stb[g]),
      .frame_err (rx_ferr[g])
    );

    uart_tx u_tx (
      .sys_clk (sys_clk),
      .srst    (srst),
      .div     (ch_div[g]),
      .start   (tx_go[g]),
      .data    (avs_writedata[7:0]),
      .busy    (tx_busy[g]),
      .txd     (txd_w[g])
    );

    // One-character holding register; a new arrival wins over the pop
    always_ff @(posedge sys_clk) begin
      if (srst) begin
        rx_full_r[g] <= 1'b0;
        rx_data_r[g] <= '0;
      end else if (rx_stb[g]) begin
        rx_full_r[g] <= 1'b1;
        rx_data_r[g] <= rx_byte[g];
      end else if (rd_do && sel_data[g]) begin
        rx_full_r[g] <= 1'b0;
      end
    end
  end

  // Protocol switch string matchers, one per control port
  for (genvar p = 0; p < NP; p++) begin : g_match
    logic [3:0] idx_r;
    logic       mach_r;
    wire  [7:0] c      = rx_byte[p];
    wire        at_sel = idx_r == 4'(scp_pkg::CMD_SEL_POS);
    wire        hit_t  = c == scp_pkg::cmd_char(idx_r, 1'b0);
    wire        hit_m  = c == scp_pkg::cmd_char(idx_r, 1'b1);
    wire        hit    = at_sel ? (hit_t | hit_m) : (mach_r ? hit_m : hit_t);
    wire        last   = idx_r == 4'(scp_pkg::CMD_LEN - 1);
    wire        star   = c == scp_pkg::CHAR_STAR;
    // A stray star may still open a fresh string
    wire  [3:0] restart = !star ? 4'h0 : (idx_r == 4'h2) ? 4'h2 : 4'h1;

    assign cmd_done[p] = rx_stb[p] & hit & last; // R13
    assign cmd_mach[p] = mach_r;

    always_ff @(posedge sys_clk) begin
      if (srst || rx_ferr[p]) begin
        idx_r  <= '0; // R13
        mach_r <= 1'b0;
      end else if (rx_stb[p]) begin
        idx_r <= (!hit || last) ? restart : idx_r + 1'b1;
        if (at_sel) mach_r <= hit_m;
      end
    end
  end

  // Mode: a completed string wins over a software write in the same cycle
  for (genvar p = 0; p < NP; p++) begin : g_mode
    assign mode_nxt[p] = cmd_done[p] ? ~cmd_mach[p] : // R04 R05
                         wr_ctrl ? avs_writedata[p] : mode_r[p];
  end

  assign terminal_mode = mode_r; // R03 R06

  // Status: sticky events, read clears only the bits returned, set wins
  wire [scp_pkg::STATUS_W-1:0] ev_set = {
    |(rx_ferr | rx_ovr), cmd_done[NP-1:0], rx_full_r
  };
  wire [scp_pkg::STATUS_W-1:0] ev_clr = (rd_do & sel_stat) ? rdata_r[scp_pkg::STATUS_W-1:0] : '0;
  assign status_nxt = (status_r & ~ev_clr) | ev_set;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      mode_r   <= scp_pkg::MODE_RST; // R01 R02
      slow_r   <= 1'b0;
      status_r <= '0;
      mask_r   <= '0;
      ack_r    <= 1'b0;
    end else begin
      mode_r   <= mode_nxt;
      status_r <= status_nxt;
      ack_r    <= take;
      if (wr_ctrl) slow_r <= avs_writedata[scp_pkg::CTRL_SLOW_BIT]; // R09
      if (wr_do && sel_mask) mask_r <= avs_writedata[scp_pkg::STATUS_W-1:0];
    end
  end

  // Configuration is written through to the non-volatile store
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      cfg_r     <= scp_pkg::CFG_RST;
      nv_wr_stb <= 1'b0;
    end else begin
      nv_wr_stb <= wr_do & sel_cfg; // R08
      if (wr_do && sel_cfg) cfg_r <= avs_writedata; // R07
    end
  end

  assign nv_wr_data = cfg_r;

  // Read data is sampled in the waiting cycle and presented with the answer
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = '0;
    if (sel_ctrl) rd_mux = 32'({slow_r, mode_r});
    if (sel_stat) rd_mux = 32'(status_r);
    if (sel_mask) rd_mux = 32'(mask_r);
    if (sel_link) rd_mux = 32'(tx_busy);
    if (sel_cfg)  rd_mux = cfg_r;
    for (int i = 0; i < NCH; i++) begin
      if (sel_data[i]) rd_mux = 32'({rx_full_r[i], rx_data_r[i]});
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) rdata_r <= '0;
    else if (avs_read && !ack_r) rdata_r <= rd_mux;
  end

  assign irq       = |(status_r & mask_r);
  assign port_txd  = txd_w[NP-1:0];
  assign panel_txd = txd_w[NP];
  assign panel_de  = tx_busy[NP]; // R12

  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  property p_rst_mode;
    $past(srst) |-> mode_r == scp_pkg::MODE_RST;
  endproperty
  a_rst_mode: assert property (p_rst_mode) else $error("Mode not default after reset"); // R02

  property p_to_term;
    cmd_done[0] && !cmd_mach[0] |=> terminal_mode[0] ##1 ($stable(terminal_mode[0]) || $past(wr_ctrl));
  endproperty
  a_to_term: assert property (p_to_term) else $error("Port 0 did not enter terminal mode"); // R04

  property p_to_mach;
    cmd_done[1] && cmd_mach[1] |=> !terminal_mode[1];
  endproperty
  a_to_mach: assert property (p_to_mach) else $error("Second port did not return to machine mode"); // R05

  property p_no_change;
    !cmd_done[1] && !wr_ctrl |=> $stable(terminal_mode[1]);
  endproperty
  a_no_change: assert property (p_no_change) else $error("Mode changed without a full string"); // R13

  property p_start_bit;
    tx_go[1] |=> !port_txd[1] [*8];
  endproperty
  a_start_bit: assert property (p_start_bit) else $error("Start bit too short"); // R02

  property p_indep;
    rx_stb[0] && !rx_full_r[0] |=> rx_full_r[0] && rx_data_r[0] == $past(rx_byte[0]);
  endproperty
  a_indep: assert property (p_indep) else $error("Received character lost"); // R01

  property p_nv;
    wr_do && sel_cfg |=> nv_wr_stb && nv_wr_data == $past(avs_writedata) ##1 !nv_wr_stb;
  endproperty
  a_nv: assert property (p_nv) else $error("Configuration not stored"); // R08

  property p_de;
    tx_go[NP] |=> panel_de && rx_in[NP];
  endproperty
  a_de: assert property (p_de) else $error("Panel driver not enabled"); // R12

  property p_rate;
    wr_ctrl && avs_writedata[scp_pkg::CTRL_SLOW_BIT] |=> ch_div[NP] == DW'(PANEL_DIV_SLOW);
  endproperty
  a_rate: assert property (p_rate) else $error("Panel rate not selected"); // R09

  c_term:  cover property (cmd_done[0] && !cmd_mach[0] && !mode_r[0]);
  c_mach:  cover property (cmd_done[1] && cmd_mach[1] && mode_r[1]);
  c_panel: cover property (rx_stb[NP]);
  c_irq:   cover property ($rose(irq));
endmodule : serial_control_port_manager

/* File: shared/scp_pkg.sv */
// How it works
// [R01] Three independent serial control ports each carry either the machine or the terminal protocol.
// [R02] After reset every port frames 115.2K baud 8N1, ports one and three machine, port two terminal.
// [R03] The terminal protocol suits an operator, the machine protocol suits a controlling computer.
// [R04] A machine-mode port that receives the select-terminal string switches to the terminal protocol.
// [R05] A port that receives the select-machine string returns to the machine protocol.
// [R06] In terminal mode the port presents an ANSI-style character terminal to plain terminals.
// [R07] The terminal interface carries system-wide configuration and makes the device the system controller.
// [R08] Configuration entered from the terminal is kept in non-volatile storage until the next change.
// [R09] The panel network runs at 31,250 or 9600 baud and all panels match the router's rate.
// [R10] Every panel on the network carries a unique ID set by its own switches.
// [R11] A panel that cannot reach the router shows a scrolling light pattern.
// [R12] The panel network serves up to 64 panels on one half-duplex RS-485 multidrop bus.
// [R13] A port changes protocol only after a complete error-free command string; anything else leaves it. The code also switches it on a write to ADDR_CTRL.
package scp_pkg;
  localparam int CLK_HZ          = 40_000_000;
  localparam int HOST_BAUD       = 115_200;
  localparam int PANEL_BAUD_FAST = 31_250;
  localparam int PANEL_BAUD_SLOW = 9_600;
  localparam int DIV_HOST        = CLK_HZ / HOST_BAUD;
  localparam int DIV_PANEL_FAST  = CLK_HZ / PANEL_BAUD_FAST;
  localparam int DIV_PANEL_SLOW  = CLK_HZ / PANEL_BAUD_SLOW;
  localparam int DIV_MIN         = 16;
  localparam int DIV_W           = 16;
  localparam int NUM_PORTS       = 3;
  localparam int NUM_CH          = NUM_PORTS + 1;
  localparam int PANEL_MAX       = 64;
  localparam int DATA_BITS       = 8;

  // Mode bit per port: 1 = terminal protocol, 0 = machine protocol
  localparam logic [NUM_PORTS-1:0] MODE_RST = 3'h2;

  // Register byte offsets
  localparam logic [5:0] ADDR_CTRL   = 6'h00;
  localparam logic [5:0] ADDR_STATUS = 6'h04;
  localparam logic [5:0] ADDR_MASK   = 6'h08;
  localparam logic [5:0] ADDR_DATA0  = 6'h0c;
  localparam logic [5:0] ADDR_LINK   = 6'h1c;
  localparam logic [5:0] ADDR_CFG    = 6'h20;
  localparam int         DATA_STEP   = 4;

  localparam int CTRL_SLOW_BIT = 3;
  localparam int DATA_FULL_BIT = 8;
  localparam int ST_MODE_LSB   = 4;
  localparam int ST_ERR_BIT    = 7;
  localparam int STATUS_W      = 8;
  localparam logic [31:0] CFG_RST = 32'h0000_0000;

  // Protocol switch strings, first character in the top byte
  localparam int          CMD_LEN     = 9;
  localparam int          CMD_SEL_POS = 6;
  localparam logic [71:0] SELECT_TERMINAL_PROTOCOL_CMD = 72'h2a_2a48_4f53_5430_2121;
  localparam logic [71:0] SELECT_MACHINE_PROTOCOL_CMD  = 72'h2a_2a48_4f53_5431_2121;
  localparam logic [7:0]  CHAR_STAR   = 8'h2a;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_START = 2'b01,
    ST_DATA  = 2'b11,
    ST_STOP  = 2'b10
  } uart_st_t;

  function automatic logic [7:0] cmd_char(input logic [3:0] idx, input logic mach);
    logic [71:0] s;
    int          k;
    s = mach ? SELECT_MACHINE_PROTOCOL_CMD : SELECT_TERMINAL_PROTOCOL_CMD;
    k = 8 * (CMD_LEN - 1 - int'(idx));
    return s[k +: 8];
  endfunction : cmd_char
endpackage : scp_pkg

/* File: verilog/uart_rx.sv */
module uart_rx (
  // Clock and reset
  input  wire logic                       sys_clk,
  input  wire logic                       srst,
  // Line and bit period
  input  wire logic                       rxd,
  input  wire logic [scp_pkg::DIV_W-1:0]  div,
  // Received character
  output logic      [7:0]                 data,
  output logic                            valid,
  output logic                            frame_err
);
  scp_pkg::uart_st_t           st_r;
  logic [scp_pkg::DIV_W-1:0]   cnt_r;
  logic [2:0]                  bit_r;

  always_ff @(posedge sys_clk) begin
    valid     <= 1'b0;
    frame_err <= 1'b0;
    if (srst) begin
      st_r  <= scp_pkg::ST_IDLE;
      cnt_r <= '0;
      bit_r <= '0;
      data  <= '0;
    end else if (st_r != scp_pkg::ST_IDLE && cnt_r != '0) begin
      cnt_r <= cnt_r - 1'b1;
    end else begin
      case (st_r)
        scp_pkg::ST_IDLE: if (!rxd) begin
          st_r  <= scp_pkg::ST_START;
          cnt_r <= div >> 1;
        end
        // A glitch shorter than half a bit is not a start bit
        scp_pkg::ST_START: begin
          st_r  <= rxd ? scp_pkg::ST_IDLE : scp_pkg::ST_DATA;
          cnt_r <= div - 1'b1;
          bit_r <= '0;
        end
        scp_pkg::ST_DATA: begin
          data  <= {rxd, data[7:1]};
          cnt_r <= div - 1'b1;
          bit_r <= bit_r + 1'b1;
          if (bit_r == 3'(scp_pkg::DATA_BITS - 1)) st_r <= scp_pkg::ST_STOP;
        end
        scp_pkg::ST_STOP: begin
          st_r      <= scp_pkg::ST_IDLE;
          valid     <= rxd;
          frame_err <= !rxd;
        end
        default: st_r <= scp_pkg::ST_IDLE;
      endcase
    end
  end
endmodule : uart_rx

/* File: verilog/uart_tx.sv */
module uart_tx (
  // Clock and reset
  input  wire logic                       sys_clk,
  input  wire logic                       srst,
  // Character to send
  input  wire logic [scp_pkg::DIV_W-1:0]  div,
  input  wire logic                       start,
  input  wire logic [7:0]                 data,
  output logic                            busy,
  // Line
  output logic                            txd
);
  scp_pkg::uart_st_t           st_r;
  logic [scp_pkg::DIV_W-1:0]   cnt_r;
  logic [2:0]                  bit_r;
  logic [7:0]                  shift_r;

  assign busy = st_r != scp_pkg::ST_IDLE;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      st_r    <= scp_pkg::ST_IDLE;
      cnt_r   <= '0;
      bit_r   <= '0;
      shift_r <= '0;
      txd     <= 1'b1;
    end else if (busy && cnt_r != '0) begin
      cnt_r <= cnt_r - 1'b1;
    end else begin
      cnt_r <= div - 1'b1;
      case (st_r)
        scp_pkg::ST_IDLE: if (start) begin
          st_r    <= scp_pkg::ST_START;
          shift_r <= data;
          txd     <= 1'b0;
        end
        scp_pkg::ST_START: begin
          st_r    <= scp_pkg::ST_DATA;
          bit_r   <= '0;
          txd     <= shift_r[0];
          shift_r <= shift_r >> 1;
        end
        scp_pkg::ST_DATA: if (bit_r == 3'(scp_pkg::DATA_BITS - 1)) begin
          st_r <= scp_pkg::ST_STOP;
          txd  <= 1'b1;
        end else begin
          bit_r   <= bit_r + 1'b1;
          txd     <= shift_r[0];
          shift_r <= shift_r >> 1;
        end
        scp_pkg::ST_STOP: st_r <= scp_pkg::ST_IDLE;
        default: st_r <= scp_pkg::ST_IDLE;
      endcase
    end
  end
endmodule : uart_tx

/* File: bench/serial_peer_model.sv */
module serial_peer_model (
  // Clock and bit period
  input  wire logic        sys_clk,
  input  wire logic [15:0] div,
  // Lines
  output logic             to_dut,
  input  wire logic        from_dut
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [15:0] rx_hist;
  logic [7:0]  sh;
  logic        lost_link;

  initial begin
    to_dut    = 1'b1;
    rx_hist   = 16'h0000;
    lost_link = 1'b0;
  end

  // Sends exactly the bytes it is given, 8N1 LSB first (stop bit low if bad_stop), at the rate set by div
  task automatic send_byte(input logic [7:0] b, input logic bad_stop);
    @(posedge sys_clk);
    to_dut <= 1'b0;
    repeat (div) @(posedge sys_clk);
    for (int i = 0; i < 8; i++) begin
      to_dut <= b[i];
      repeat (div) @(posedge sys_clk);
    end
    to_dut <= ~bad_stop;
    repeat (div) @(posedge sys_clk);
    to_dut <= 1'b1;
    repeat (2) @(posedge sys_clk);
  endtask : send_byte

  // Receiver samples mid bit; a peer at another rate would garble these
  always begin
    @(negedge from_dut);
    repeat (div / 2) @(posedge sys_clk);
    for (int i = 0; i < 8; i++) begin
      repeat (div) @(posedge sys_clk);
      sh[i] = from_dut;
    end
    repeat (div) @(posedge sys_clk);
    // A real panel would scroll its lights here; the bench reads the flag
    if (from_dut !== 1'b1) lost_link = 1'b1;
    rx_hist = {rx_hist[7:0], sh};
  end
endmodule : serial_peer_model

/* File: bench/tb_serial_control_port_manager.sv */
module tb_serial_control_port_manager;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {
    logic [5:0]  a;
    logic [31:0] wd;
    logic [31:0] rd;
    logic [2:0]  md;
  } row_t;

  localparam logic [15:0] HDIV = 16'h0010;
  localparam logic [71:0] SEL_T = scp_pkg::SELECT_TERMINAL_PROTOCOL_CMD;
  localparam logic [71:0] SEL_M = scp_pkg::SELECT_MACHINE_PROTOCOL_CMD;
  localparam row_t ROWS [7] = '{
    '{scp_pkg::ADDR_CTRL, 32'hd, 32'hd, 3'h5}, '{scp_pkg::ADDR_CTRL, 32'h2, 32'h2, 3'h2},
    '{scp_pkg::ADDR_MASK, 32'hff, 32'hff, 3'h2}, '{scp_pkg::ADDR_MASK, 32'h0, 32'h0, 3'h2},
    '{scp_pkg::ADDR_CFG, 32'ha5c30f96, 32'ha5c30f96, 3'h2}, '{scp_pkg::ADDR_LINK, 32'hf, 32'h0, 3'h2},
    '{6'h3c, 32'hffffffff, 32'h0, 3'h2}};

  logic        sys_clk, srst, avs_read, avs_write, avs_waitrequest, irq, panel_txd, panel_de, nv_wr_stb, de_seen;
  logic [5:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, nv_wr_data, nv_last, d;
  logic [2:0]  port_txd, terminal_mode;
  logic [15:0] pan_div;
  wire  [2:0]  port_rxd;
  wire         panel_rxd;
  int          fail_count, total_checks, nv_cnt;

  serial_control_port_manager #(.HOST_DIV(16), .PANEL_DIV_FAST(32), .PANEL_DIV_SLOW(64)) dut (
    .sys_clk(sys_clk), .srst(srst), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq),
    .port_rxd(port_rxd), .port_txd(port_txd), .terminal_mode(terminal_mode), .panel_rxd(panel_rxd),
    .panel_txd(panel_txd), .panel_de(panel_de), .nv_wr_stb(nv_wr_stb), .nv_wr_data(nv_wr_data));

  serial_peer_model mp0 (.sys_clk(sys_clk), .div(HDIV), .to_dut(port_rxd[0]), .from_dut(port_txd[0]));
  serial_peer_model mp1 (.sys_clk(sys_clk), .div(HDIV), .to_dut(port_rxd[1]), .from_dut(port_txd[1]));
  serial_peer_model mp2 (.sys_clk(sys_clk), .div(HDIV), .to_dut(port_rxd[2]), .from_dut(port_txd[2]));
  // Only panel on the bus, so its ID cannot clash
  serial_peer_model mpan (.sys_clk(sys_clk), .div(pan_div), .to_dut(panel_rxd), .from_dut(panel_txd));

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    if (nv_wr_stb === 1'b1) begin
      nv_cnt++;
      nv_last = nv_wr_data;
    end
    if (panel_de === 1'b1) de_seen = 1'b1;
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : wrap_up

  task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : check

  // Request held until waitrequest is sampled low at a rising edge
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] wd, output logic [31:0] rd);
    int n;
    @(posedge sys_clk);
    avs_address   <= a;
    avs_writedata <= wd;
    avs_write     <= wr;
    avs_read      <= ~wr;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 5000);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    if (avs_waitrequest !== 1'b0) begin
      fail_count++;
      wrap_up();
    end
  endtask : bus

  // Each character is popped as it lands so no overrun muddies the status
  task automatic send_port(input int p, input logic [79:0] s, input int n, input logic bad_last);
    logic [7:0] c;
    logic       bad;
    for (int i = 0; i < n; i++) begin
      c = s[8*(n-1-i) +: 8];
      bad = bad_last && (i == n - 1);
      case (p)
        0: mp0.send_byte(c, bad);
        1: mp1.send_byte(c, bad);
        2: mp2.send_byte(c, bad);
        default: mpan.send_byte(c, bad);
      endcase
      bus(1'b0, scp_pkg::ADDR_DATA0 + 6'(4 * p), 32'h0, d);
      if (!bad) check("rx char", d, {23'h0, 1'b1, c});
    end
  endtask : send_port

  task automatic wait_tx(input int p, input logic [15:0] exp);
    logic [15:0] h;
    for (int n = 0; n < 3000; n++) begin
      @(posedge sys_clk);
      h = (p == 0) ? mp0.rx_hist : mpan.rx_hist;
      if (h === exp) break;
    end
    check("tx bytes", {16'h0, h}, {16'h0, exp});
  endtask : wait_tx

  initial begin
    srst = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 6'h00;
    avs_writedata = 32'h0;
    pan_div = 16'h0020;
    fail_count = 0;
    total_checks = 0;
    nv_cnt = 0;
    de_seen = 1'b0;
    repeat (20) @(posedge sys_clk);
    srst <= 1'b0;
    #1;
    check("mode", {29'h0, terminal_mode}, 32'h2);
    check("idle lines", {28'h0, panel_de, port_txd}, 32'h7);
    check("irq", {31'h0, irq}, 32'h0);
    foreach (ROWS[i]) begin
      bus(1'b1, ROWS[i].a, ROWS[i].wd, d);
      bus(1'b0, ROWS[i].a, 32'h0, d);
      check("reg read", d, ROWS[i].rd);
      check("mode", {29'h0, terminal_mode}, {29'h0, ROWS[i].md});
    end
    check("nv data", nv_last, 32'ha5c30f96);
    check("nv count", 32'(nv_cnt), 32'h1);
    bus(1'b0, scp_pkg::ADDR_STATUS, 32'h0, d);
    send_port(0, 80'(SEL_T), 9, 1'b0);
    check("mode", {29'h0, terminal_mode}, 32'h3);
    check("irq masked", {31'h0, irq}, 32'h0);
    bus(1'b1, scp_pkg::ADDR_MASK, 32'h10, d);
    #1 check("irq", {31'h0, irq}, 32'h1);
    bus(1'b0, scp_pkg::ADDR_STATUS, 32'h0, d);
    check("status", d & 32'hf0, 32'h10);
    #1 check("irq cleared", {31'h0, irq}, 32'h0);
    send_port(1, 80'(SEL_M), 9, 1'b0);
    check("mode", {29'h0, terminal_mode}, 32'h1);
    bus(1'b0, scp_pkg::ADDR_STATUS, 32'h0, d);
    // Short, corrupted and broken-stop strings must all leave port three alone
    send_port(2, 80'(SEL_T[63:0]), 8, 1'b0);
    send_port(2, {SEL_T[71:16], 8'h58, SEL_T[15:0]}, 10, 1'b0);
    send_port(2, 80'(SEL_T), 9, 1'b1);
    check("mode", {29'h0, terminal_mode}, 32'h1);
    bus(1'b0, scp_pkg::ADDR_STATUS, 32'h0, d);
    check("status", d & 32'hf0, 32'h80);
    send_port(2, {scp_pkg::CHAR_STAR, SEL_T}, 10, 1'b0);
    check("mode", {29'h0, terminal_mode}, 32'h5);
    bus(1'b0, scp_pkg::ADDR_STATUS, 32'h0, d);
    check("status", d & 32'hf0, 32'h40);
    mp1.send_byte(8'h41, 1'b0);
    mp1.send_byte(8'h42, 1'b0);
    bus(1'b0, scp_pkg::ADDR_DATA0 + 6'h04, 32'h0, d);
    check("overrun char", d, 32'h142);
    bus(1'b0, scp_pkg::ADDR_STATUS, 32'h0, d);
    check("overrun", d & 32'hf0, 32'h80);
    bus(1'b1, scp_pkg::ADDR_DATA0, 32'h5a, d);
    bus(1'b1, scp_pkg::ADDR_DATA0, 32'hc3, d);
    wait_tx(0, 16'h5ac3);
    bus(1'b1, scp_pkg::ADDR_CTRL, 32'h5, d);
    bus(1'b1, scp_pkg::ADDR_DATA0 + 6'h0c, 32'ha5, d);
    bus(1'b0, scp_pkg::ADDR_LINK, 32'h0, d);
    check("link busy", d & 32'h8, 32'h8);
    wait_tx(3, 16'h00a5);
    check("driver enable", {31'h0, de_seen}, 32'h1);
    pan_div <= 16'h0040;
    bus(1'b1, scp_pkg::ADDR_CTRL, 32'hd, d);
    bus(1'b1, scp_pkg::ADDR_DATA0 + 6'h0c, 32'h3c, d);
    wait_tx(3, 16'ha53c);
    // Receive is deaf while the driver is on, so let the stop bit finish
    repeat (64) @(posedge sys_clk);
    send_port(3, 80'h71, 1, 1'b0);
    check("panel link", {31'h0, mpan.lost_link}, 32'h0);
    srst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    srst <= 1'b0;
    #1 check("mode", {29'h0, terminal_mode}, 32'h2);
    bus(1'b0, scp_pkg::ADDR_CTRL, 32'h0, d);
    check("ctrl", d, 32'h2);
    bus(1'b0, scp_pkg::ADDR_CFG, 32'h0, d);
    check("cfg", d, scp_pkg::CFG_RST);
    wrap_up();
  end
endmodule : tb_serial_control_port_manager
